// File: tlcs_top.v
// The implementer's own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/10ps
`include "tlcs_consts.vh"
module tlcs_top #(
	parameter NCH = 4,
	parameter DW  = 20
) (
	input  wire              clock,
	input  wire              rst_b,
	input  wire              ce,
	input  wire              s_axi_awvalid,
	output wire              s_axi_awready,
	input  wire [7:0]        s_axi_awaddr,
	input  wire              s_axi_wvalid,
	output wire              s_axi_wready,
	input  wire [31:0]       s_axi_wdata,
	input  wire [3:0]        s_axi_wstrb,
	output reg               s_axi_bvalid,
	input  wire              s_axi_bready,
	output reg  [1:0]        s_axi_bresp,
	input  wire              s_axi_arvalid,
	output wire              s_axi_arready,
	input  wire [7:0]        s_axi_araddr,
	output reg               s_axi_rvalid,
	input  wire              s_axi_rready,
	output reg  [31:0]       s_axi_rdata,
	output reg  [1:0]        s_axi_rresp,
	input  wire [NCH-1:0]    serial_loop_en,
	input  wire [NCH-1:0]    pipe_loop_req,
	input  wire [NCH*DW-1:0] core_tx_data,
	output wire [NCH*DW-1:0] core_rx_data,
	input  wire [NCH*DW-1:0] line_rx_rec,
	input  wire [NCH*DW-1:0] line_rx_pre,
	output wire [NCH*DW-1:0] line_tx_data,
	output wire [NCH-1:0]    line_tx_emph_on,
	output wire [2:0]        line_tx_swing,
	output wire [2:0]        line_tx_emph,
	output wire [NCH-1:0]    builtin_pattern_test_err,
	output wire [3:0]        rx_fifo_depth,
	output wire [1:0]        tx_pll_ref_sel,
	output wire [7:0]        rx_pll_src,
	output wire              interblock_ref_sel,
	output wire              interblock_en,
	output wire [3:0]        regional_clk_en,
	output wire [2:0]        global_clk_src,
	output wire              irq
);
	reg  [31:0]      proto_q;
	reg  [31:0]      loopsel_q;
	reg  [31:0]      clksel_q;
	reg  [31:0]      analog_q;
	reg  [31:0]      mask_q;
	reg  [31:0]      status_q;
	reg  [31:0]      status_d;
	reg              aw_h_q;
	reg              w_h_q;
	reg  [7:0]       awaddr_q;
	reg  [31:0]      wdata_q;
	reg  [3:0]       wstrb_q;
	reg  [31:0]      rd_d;
	reg              rd_hit;
	reg              wr_hit;
	reg              irq_q;
	reg  [3:0]       depth_q;
	wire [NCH-1:0]   ev_err;
	wire [NCH-1:0]   ev_bad;
	wire [NCH*3-1:0] eff_mode;
	wire             wr_go;
	wire             rd_take;
	wire             pipe_on;
	wire             basic_on;
	wire             dw_on;
	wire             builtin_pattern_test_req;

	assign pipe_on = proto_q[`TLCS_B_PIPE];
	assign basic_on = proto_q[`TLCS_B_BASIC];
	assign dw_on = proto_q[`TLCS_B_DWIDTH];
	assign builtin_pattern_test_req = proto_q[`TLCS_B_BUILTIN_PATTERN_TEST];

	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0]  strb;
		integer      b;
		begin
			merge = old;
			for (b = 0; b < 4; b = b + 1)
				if (strb[b])
					merge[b*8 +: 8] = nw[b*8 +: 8];
		end
	endfunction

	// Write side: address and data may arrive in either order
	assign s_axi_awready = ce && !aw_h_q && !s_axi_bvalid;
	assign s_axi_wready = ce && !w_h_q && !s_axi_bvalid;
	assign wr_go = aw_h_q && w_h_q;

	always @* begin
		wr_hit = 1'b0;
		if (awaddr_q == `TLCS_OFF_PROTO)
			wr_hit = 1'b1;
		else if (awaddr_q == `TLCS_OFF_LOOPSEL)
			wr_hit = 1'b1;
		else if (awaddr_q == `TLCS_OFF_CLKSEL)
			wr_hit = 1'b1;
		else if (awaddr_q == `TLCS_OFF_ANALOG)
			wr_hit = 1'b1;
		else if (awaddr_q == `TLCS_OFF_MASK)
			wr_hit = 1'b1;
	end

	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			aw_h_q <= 1'b0;
			w_h_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `TLCS_RESP_OKAY;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_h_q <= 1'b1;
				awaddr_q <= {s_axi_awaddr[7:2], 2'b00};
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_h_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_h_q <= 1'b0;
				w_h_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ? `TLCS_RESP_OKAY : `TLCS_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			proto_q <= `TLCS_RST_PROTO;
			loopsel_q <= `TLCS_RST_LOOPSEL;
			clksel_q <= `TLCS_RST_CLKSEL;
			analog_q <= `TLCS_RST_ANALOG;
			mask_q <= `TLCS_RST_MASK;
		end else if (ce && wr_go) begin
			if (awaddr_q == `TLCS_OFF_PROTO)
				proto_q <= merge(proto_q, wdata_q, wstrb_q);
			else if (awaddr_q == `TLCS_OFF_LOOPSEL)
				loopsel_q <= merge(loopsel_q, wdata_q, wstrb_q);
			else if (awaddr_q == `TLCS_OFF_CLKSEL)
				clksel_q <= merge(clksel_q, wdata_q, wstrb_q);
			else if (awaddr_q == `TLCS_OFF_ANALOG)
				analog_q <= merge(analog_q, wdata_q, wstrb_q);
			else if (awaddr_q == `TLCS_OFF_MASK)
				mask_q <= merge(mask_q, wdata_q, wstrb_q);
		end
	end

	// Read side
	assign s_axi_arready = ce && !s_axi_rvalid;
	assign rd_take = s_axi_arvalid && s_axi_arready;

	always @* begin
		rd_d = 32'h0000_0000;
		rd_hit = 1'b1;
		if (s_axi_araddr[7:2] == `TLCS_OFF_PROTO >> 2)
			rd_d = proto_q;
		else if (s_axi_araddr[7:2] == `TLCS_OFF_LOOPSEL >> 2)
			rd_d = loopsel_q;
		else if (s_axi_araddr[7:2] == `TLCS_OFF_CLKSEL >> 2)
			rd_d = clksel_q;
		else if (s_axi_araddr[7:2] == `TLCS_OFF_ANALOG >> 2)
			rd_d = analog_q;
		else if (s_axi_araddr[7:2] == `TLCS_OFF_STATUS >> 2)
			rd_d = status_q;
		else if (s_axi_araddr[7:2] == `TLCS_OFF_MASK >> 2)
			rd_d = mask_q;
		else if (s_axi_araddr[7:2] == `TLCS_OFF_ACTIVE >> 2)
			rd_d = {rx_fifo_depth, {(28-NCH*3){1'b0}}, eff_mode};
		else
			rd_hit = 1'b0;
	end

	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `TLCS_RESP_OKAY;
		end else if (ce) begin
			if (rd_take) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_d;
				s_axi_rresp <= rd_hit ? `TLCS_RESP_OKAY : `TLCS_RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Sticky events; a new event beats the read that clears
	always @* begin
		status_d = status_q;
		if (rd_take && s_axi_araddr[7:2] == `TLCS_OFF_STATUS >> 2)
			status_d = 32'h0000_0000;
		status_d[NCH-1:0] = status_d[NCH-1:0] | ev_err;
		status_d[2*NCH-1:NCH] = status_d[2*NCH-1:NCH] | ev_bad;
	end

	always @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			status_q <= 32'h0000_0000;
		else if (ce)
			status_q <= status_d;
	end

	// Registered, so the pin lags the status bit by one cycle
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			irq_q <= 1'b0;
		else if (ce)
			irq_q <= |(status_q & mask_q);
	end

	assign irq = irq_q;
	assign builtin_pattern_test_err = ev_err;

	// Analog output settings and receive phase buffer depth
	assign line_tx_swing = analog_q[`TLCS_F_SWING];
	assign line_tx_emph = analog_q[`TLCS_F_EMPH];
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			depth_q <= `TLCS_DEPTH_OTHER;
		else if (ce)
			depth_q <= pipe_on ? `TLCS_DEPTH_PIPE : `TLCS_DEPTH_OTHER;
	end

	assign rx_fifo_depth = depth_q;

	// Clock routing; the encodings leave no illegal source reachable
	assign tx_pll_ref_sel = clksel_q[`TLCS_F_TXREF];
	// Per receive PLL: 0/1 reference clock, 2/3 transmit PLL output
	assign rx_pll_src = clksel_q[`TLCS_F_RXSRC];
	// Single select bit, so only one reference clock leaves the block
	assign interblock_ref_sel = clksel_q[`TLCS_B_IBSEL];
	assign interblock_en = clksel_q[`TLCS_B_IBEN];
	assign regional_clk_en = clksel_q[`TLCS_F_REGEN];
	// 0/1 reference, 2/3 transmit PLL, 4..7 recovered clock
	assign global_clk_src = clksel_q[`TLCS_F_GLOBSRC];

	genvar c;
	generate
		for (c = 0; c < NCH; c = c + 1) begin : g_ch
			wire [2:0]    req;
			wire [DW-1:0] gen;
			wire          builtin_pattern_test_on;
			wire [DW-1:0] txw;
			reg  [2:0]    m;
			reg           bad;
			reg  [2:0]    mode_q;
			reg  [DW-1:0] crx_q;
			reg  [DW-1:0] ltx_q;
			reg           emph_q;

			assign req = loopsel_q[c*3 +: 3];

			// Pins win over the register; one path at most
			always @* begin
				m = `TLCS_M_NONE;
				bad = 1'b0;
				if (pipe_on && pipe_loop_req[c]) begin
					m = `TLCS_M_REVPAR;
				end else if (serial_loop_en[c] || req == `TLCS_M_SERIAL) begin
					if (!pipe_on)
						m = `TLCS_M_SERIAL;
					else
						bad = 1'b1;
				end else if (req == `TLCS_M_PAR) begin
					if (basic_on && dw_on && !pipe_on)
						m = `TLCS_M_PAR;
					else
						bad = 1'b1;
				end else if (req == `TLCS_M_REVSER) begin
					m = `TLCS_M_REVSER;
				end else if (req == `TLCS_M_REVPRE) begin
					m = `TLCS_M_REVPRE;
				end else if (req != `TLCS_M_NONE || pipe_loop_req[c]) begin
					bad = 1'b1;
				end
			end

			assign ev_bad[c] = bad;
			assign builtin_pattern_test_on = (builtin_pattern_test_req && basic_on && !pipe_on) || m == `TLCS_M_PAR;
			assign txw = builtin_pattern_test_on ? gen : core_tx_data[c*DW +: DW];

			tlcs_prbs #(
				.W (DW)
			) u_prbs (
				.clock   (clock),
				.rst_b   (rst_b),
				.ce      (ce),
				.enable  (builtin_pattern_test_on),
				.narrow  (!dw_on),
				.rx_word (crx_q),
				.gen_q   (gen),
				.err_q   (ev_err[c])
			);

			always @(posedge clock or negedge rst_b) begin
				if (!rst_b) begin
					mode_q <= `TLCS_M_NONE;
					crx_q <= {DW{1'b0}};
					ltx_q <= {DW{1'b0}};
					emph_q <= 1'b1;
				end else if (ce) begin
					mode_q <= m;
					// Pre-recovery path: swing kept, pre-emphasis off
					emph_q <= (m != `TLCS_M_REVPRE);
					case (m)
					`TLCS_M_REVSER, `TLCS_M_REVPAR: begin
						ltx_q <= line_rx_rec[c*DW +: DW];
						crx_q <= line_rx_rec[c*DW +: DW];
					end
					`TLCS_M_REVPRE: begin
						ltx_q <= line_rx_pre[c*DW +: DW];
						crx_q <= line_rx_rec[c*DW +: DW];
					end
					`TLCS_M_SERIAL, `TLCS_M_PAR: begin
						// Line still carries the transmit stream
						ltx_q <= txw;
						crx_q <= txw;
					end
					default: begin
						ltx_q <= txw;
						crx_q <= line_rx_rec[c*DW +: DW];
					end
					endcase
				end
			end

			assign eff_mode[c*3 +: 3] = mode_q;
			assign core_rx_data[c*DW +: DW] = crx_q;
			assign line_tx_data[c*DW +: DW] = ltx_q;
			assign line_tx_emph_on[c] = emph_q;
		end
	endgenerate
endmodule

// File: tlcs_consts.vh
// What this block does
// - Core logic turns serial loopback on or off per channel by a pin.
// - Serial loopback exists in every protocol mode except PIPE.
// - Built-in test: PRBS-7 at 20-bit width, PRBS-10 at 10-bit width.
// - Parallel loopback only in Basic mode with double-width data.
// - Parallel loopback sends built-in generator data, returned before analog section.
// - Parallel loopback runs the built-in checker on returned data, flags errors.
// - Reverse serial loopback returns recovered, retimed receive data to transmitter.
// - Pre-recovery reverse loopback keeps output swing, ignores pre-emphasis.
// - Reverse parallel loopback only in PIPE mode, requested by PIPE pin.
// - Two transmit PLLs, four receive PLLs, each fed by either reference clock.
// - Transmit PLL output reaches only global lines and receive PLL reference.
// - Only one reference clock of a block drives the inter-block lines.
// - Recovered clocks drive adjacent regional clocks and global clocks.
// - Receive phase buffer is eight deep in PIPE, four otherwise.
`ifndef TLCS_CONSTS_VH
`define TLCS_CONSTS_VH
`define TLCS_OFF_PROTO   8'h00
`define TLCS_OFF_LOOPSEL 8'h04
`define TLCS_OFF_CLKSEL  8'h08
`define TLCS_OFF_ANALOG  8'h0c
`define TLCS_OFF_STATUS  8'h10
`define TLCS_OFF_MASK    8'h14
`define TLCS_OFF_ACTIVE  8'h18
`define TLCS_RST_PROTO   32'h0000_0000
`define TLCS_RST_LOOPSEL 32'h0000_0000
`define TLCS_RST_CLKSEL  32'h0000_0000
`define TLCS_RST_ANALOG  32'h0000_0000
`define TLCS_RST_MASK    32'h0000_0000
`define TLCS_B_PIPE      0
`define TLCS_B_BASIC     1
`define TLCS_B_DWIDTH    2
`define TLCS_B_BUILTIN_PATTERN_TEST      3
`define TLCS_F_TXREF     1:0
`define TLCS_F_RXSRC     9:2
`define TLCS_B_IBSEL     10
`define TLCS_B_IBEN      11
`define TLCS_F_REGEN     15:12
`define TLCS_F_GLOBSRC   18:16
`define TLCS_F_SWING     2:0
`define TLCS_F_EMPH      6:4
`define TLCS_M_NONE      3'h0
`define TLCS_M_SERIAL    3'h1
`define TLCS_M_PAR       3'h2
`define TLCS_M_REVSER    3'h3
`define TLCS_M_REVPRE    3'h4
`define TLCS_M_REVPAR    3'h5
`define TLCS_DEPTH_PIPE  4'h8
`define TLCS_DEPTH_OTHER 4'h4
`define TLCS_RESP_OKAY   2'b00
`define TLCS_RESP_SLVERR 2'b10
`define TLCS_PRBS_SEED   10'h3ff
`define TLCS_PRIME_WORDS 2'h3
`endif

// File: tlcs_prbs.v
`timescale 1ns/10ps
`include "tlcs_consts.vh"
module tlcs_prbs #(
	parameter W = 20
) (
	input  wire         clock,
	input  wire         rst_b,
	input  wire         ce,
	input  wire         enable,
	input  wire         narrow,
	input  wire [W-1:0] rx_word,
	output reg  [W-1:0] gen_q,
	output reg          err_q
);
	reg [9:0]   gst_q;
	reg [9:0]   hist_q;
	reg [1:0]   primed_q;
	reg [9:0]   g;
	reg [9:0]   h;
	reg [W-1:0] gw;
	reg         e;
	reg         nb;
	reg         pb;
	integer     i;

	// Self-synchronising check: each bit is predicted from earlier received bits
	always @* begin
		g = gst_q;
		h = hist_q;
		gw = {W{1'b0}};
		e = 1'b0;
		nb = 1'b0;
		pb = 1'b0;
		for (i = 0; i < W; i = i + 1) begin
			if (!narrow || i < W / 2) begin
				nb = narrow ? (g[9] ^ g[6]) : (g[6] ^ g[5]);
				gw[i] = nb;
				g = {g[8:0], nb};
				pb = narrow ? (h[9] ^ h[6]) : (h[6] ^ h[5]);
				if (rx_word[i] != pb)
					e = 1'b1;
				h = {h[8:0], rx_word[i]};
			end
		end
	end

	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			gst_q <= `TLCS_PRBS_SEED;
			hist_q <= 10'h000;
			primed_q <= 2'h0;
			gen_q <= {W{1'b0}};
			err_q <= 1'b0;
		end else if (ce) begin
			if (enable) begin
				gst_q <= g;
				hist_q <= h;
				gen_q <= gw;
				// Two stale pipeline words and one history fill go unchecked
				if (primed_q != `TLCS_PRIME_WORDS)
					primed_q <= primed_q + 2'h1;
				err_q <= e & (primed_q == `TLCS_PRIME_WORDS);
			end else begin
				gst_q <= `TLCS_PRBS_SEED;
				primed_q <= 2'h0;
				err_q <= 1'b0;
			end
		end
	end
endmodule

// File: tlcs_properties.sv
`timescale 1ns/10ps
module tlcs_properties #(
	parameter NCH = 4,
	parameter DW  = 20
) (
	input wire              clock,
	input wire              rst_b,
	input wire              s_axi_awvalid,
	input wire              s_axi_awready,
	input wire              s_axi_wvalid,
	input wire              s_axi_wready,
	input wire              s_axi_bvalid,
	input wire              s_axi_arvalid,
	input wire              s_axi_arready,
	input wire              s_axi_rvalid,
	input wire [NCH-1:0]    serial_loop_en,
	input wire [NCH-1:0]    pipe_loop_req,
	input wire [NCH*DW-1:0] core_rx_data,
	input wire [NCH*DW-1:0] line_rx_rec,
	input wire [NCH*DW-1:0] line_rx_pre,
	input wire [NCH*DW-1:0] line_tx_data,
	input wire [NCH-1:0]    line_tx_emph_on,
	input wire [2:0]        line_tx_swing,
	input wire [2:0]        line_tx_emph,
	input wire [3:0]        rx_fifo_depth
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);

	AST_WRITE_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##2 s_axi_bvalid) else $error("late write answer");
	AST_READ_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("late read answer");
	AST_AW_BLOCKED: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("address taken during answer");
	AST_FIFO_DEPTH: assert property (rx_fifo_depth == 4'h4 || rx_fifo_depth == 4'h8)
		else $error("bad buffer depth");
	AST_SERIAL_LOOP: assert property (serial_loop_en[0] && rx_fifo_depth == 4'h4
		|=> core_rx_data[DW-1:0] == line_tx_data[DW-1:0]) else $error("serial loop");
	AST_PRE_RECOVERY: assert property (!line_tx_emph_on[0]
		|-> line_tx_data[DW-1:0] == $past(line_rx_pre[DW-1:0])) else $error("pre loop");
	AST_PIPE_LOOP: assert property (pipe_loop_req[0] && rx_fifo_depth == 4'h8
		|=> line_tx_data[DW-1:0] == $past(line_rx_rec[DW-1:0])
		&& core_rx_data[DW-1:0] == line_tx_data[DW-1:0]) else $error("pipe loop");
	AST_ANALOG_WRITE: assert property (!$stable({line_tx_swing, line_tx_emph})
		|-> $rose(s_axi_bvalid)) else $error("swing moved without write");
endmodule

bind tlcs_top tlcs_properties #(.NCH(NCH), .DW(DW)) chk_i (.*);

// File: tlcs_partner.sv
`timescale 1ns/10ps
// Far-side source; word moves every cycle so stale data shows
module tlcs_partner #(
	parameter NCH = 4
) (
	input  wire              clock,
	input  wire              rst_b,
	output wire [NCH*20-1:0] line_rx_rec,
	output wire [NCH*20-1:0] line_rx_pre
);
	reg [15:0] step_q;

	always @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			step_q <= 16'h0000;
		else
			step_q <= step_q + 16'h0001;
	end
	// Distinct words tell the two return paths apart
	assign line_rx_rec = {NCH{step_q, 4'h5}};
	assign line_rx_pre = {NCH{~step_q, 4'ha}};
endmodule

// File: transceiver_loopback_and_clock_select_bench.sv
`timescale 1ns/10ps
`include "tlcs_consts.vh"
module transceiver_loopback_and_clock_select_bench;
	localparam [31:0] CK = 32'h0005_a9b6;
	reg        clock, rst_b, ce, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	reg        s_axi_arvalid, s_axi_rready;
	reg [7:0]  s_axi_awaddr, s_axi_araddr, a;
	reg [31:0] s_axi_wdata;
	reg [3:0]  s_axi_wstrb, serial_loop_en, pipe_loop_req;
	reg [79:0] core_tx_data, rec_q, pre_q;
	wire       s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire       irq, interblock_ref_sel, interblock_en;
	wire [1:0] s_axi_bresp, s_axi_rresp, tx_pll_ref_sel;
	wire [31:0] s_axi_rdata;
	wire [79:0] core_rx_data, line_rx_rec, line_rx_pre, line_tx_data;
	wire [3:0] line_tx_emph_on, builtin_pattern_test_err, rx_fifo_depth, regional_clk_en;
	wire [2:0] line_tx_swing, line_tx_emph, global_clk_src;
	wire [7:0] rx_pll_src;
	integer    bad_count, compares, errs;

	tlcs_top #(.NCH(4), .DW(20)) DUT (.*);
	tlcs_partner #(.NCH(4)) far_end (.*);

	initial begin
		clock = 1'h0;
		forever #10 clock = ~clock;
	end
	// Bench copy of what the design saw one edge earlier
	always @(posedge clock) begin
		rec_q <= line_rx_rec;
		pre_q <= line_rx_pre;
		// Only channel 0 is looped; the others see foreign data
		if (rst_b && builtin_pattern_test_err[0])
			errs = errs + 1;
	end

	task chk(input string nm, input [31:0] seen, input [31:0] exp);
		begin
			compares = compares + 1;
			if (seen !== exp) begin
				bad_count = bad_count + 1;
				$display("wrong value %s expected %h seen %h", nm, exp, seen);
			end
		end
	endtask
	task test_done;
		begin
			if (bad_count == 0 && compares > 0)
				$display("Finished cleanly");
			else
				$display("Finished with errors");
			$finish;
		end
	endtask
	task hang;
		begin
			bad_count = bad_count + 1;
			test_done;
		end
	endtask
	task wr(input [7:0] ad, input [31:0] d, input [1:0] er);
		integer n;
		reg     got;
		begin
			@(posedge clock);
			s_axi_awaddr <= ad;
			s_axi_wdata <= d;
			s_axi_awvalid <= 1'h1;
			s_axi_wvalid <= 1'h1;
			s_axi_bready <= 1'h1;
			got = 1'h0;
			for (n = 0; n < 40 && !got; n = n + 1) begin
				@(posedge clock);
				if (s_axi_awready)
					s_axi_awvalid <= 1'h0;
				if (s_axi_wready)
					s_axi_wvalid <= 1'h0;
				if (s_axi_bvalid) begin
					s_axi_bready <= 1'h0;
					got = 1'h1;
					chk("bresp", s_axi_bresp, er);
				end
			end
			if (!got)
				hang;
		end
	endtask
	task rd(input string nm, input [7:0] ad, input [31:0] ed, input [1:0] er);
		integer n;
		reg     got;
		begin
			@(posedge clock);
			s_axi_araddr <= ad;
			s_axi_arvalid <= 1'h1;
			s_axi_rready <= 1'h1;
			got = 1'h0;
			for (n = 0; n < 40 && !got; n = n + 1) begin
				@(posedge clock);
				if (s_axi_arready)
					s_axi_arvalid <= 1'h0;
				if (s_axi_rvalid) begin
					s_axi_rready <= 1'h0;
					got = 1'h1;
					chk(nm, s_axi_rdata, ed);
					chk("rresp", s_axi_rresp, er);
				end
			end
			if (!got)
				hang;
		end
	endtask

	task t_regs;
		begin
			for (a = 8'h00; a < 8'h18; a = a + 8'h04)
				rd("reset", a, 32'h0000_0000, 2'h0);
			rd("hole", 8'h1c, 32'h0000_0000, 2'h2);
			wr(8'h10, 32'h0000_0001, 2'h2);
			wr(8'h08, CK, 2'h0);
			rd("clksel", 8'h08, CK, 2'h0);
			chk("txref", tx_pll_ref_sel, CK[`TLCS_F_TXREF]);
			chk("rxsrc", rx_pll_src, CK[`TLCS_F_RXSRC]);
			chk("ibsel", interblock_ref_sel, CK[`TLCS_B_IBSEL]);
			chk("iben", interblock_en, CK[`TLCS_B_IBEN]);
			chk("regen", regional_clk_en, CK[`TLCS_F_REGEN]);
			chk("glob", global_clk_src, CK[`TLCS_F_GLOBSRC]);
		end
	endtask
	task t_serial;
		begin
			@(posedge clock);
			core_tx_data <= {20'h4_4444, 20'h3_3333, 20'h2_2222, 20'h1_1111};
			serial_loop_en <= 4'h1;
			repeat (2) @(negedge clock);
			chk("ser rx", core_rx_data[19:0], 20'h1_1111);
			chk("ser tx", line_tx_data[19:0], 20'h1_1111);
			chk("norm tx", line_tx_data[39:20], 20'h2_2222);
			chk("norm rx", core_rx_data[39:20], rec_q[39:20]);
			rd("active", 8'h18, 32'h4000_0001, 2'h0);
			@(posedge clock);
			serial_loop_en <= 4'h0;
		end
	endtask
	task t_pipe;
		begin
			wr(8'h00, 32'h0000_0001, 2'h0);
			wr(8'h14, 32'h0000_0020, 2'h0);
			chk("depth", rx_fifo_depth, 4'h8);
			chk("irq idle", irq, 1'h0);
			@(posedge clock);
			pipe_loop_req <= 4'h1;
			serial_loop_en <= 4'h2;
			repeat (3) @(negedge clock);
			chk("rpar tx", line_tx_data[19:0], rec_q[19:0]);
			chk("rpar rx", core_rx_data[19:0], rec_q[19:0]);
			chk("irq", irq, 1'h1);
			rd("active", 8'h18, 32'h8000_0005, 2'h0);
			@(posedge clock);
			pipe_loop_req <= 4'h0;
			serial_loop_en <= 4'h0;
			rd("status", 8'h10, 32'h0000_0020, 2'h0);
			rd("cleared", 8'h10, 32'h0000_0000, 2'h0);
			chk("irq off", irq, 1'h0);
			wr(8'h00, 32'h0000_0000, 2'h0);
		end
	endtask
	task t_builtin_pattern_test;
		begin
			wr(8'h00, 32'h0000_0006, 2'h0);
			wr(8'h04, 32'h0000_0002, 2'h0);
			errs = 0;
			repeat (40) @(negedge clock);
			chk("par errs", errs, 0);
			chk("par gen", line_tx_data[19:0] !== 20'h1_1111, 1'h1);
			rd("active", 8'h18, 32'h4000_0002, 2'h0);
			// Checker stops in the same cycle as the path breaks, so no false errors
			wr(8'h04, 32'h0000_0000, 2'h0);
			wr(8'h00, 32'h0000_0000, 2'h0);
			@(posedge clock);
			serial_loop_en <= 4'h1;
			wr(8'h00, 32'h0000_000a, 2'h0);
			errs = 0;
			repeat (40) @(negedge clock);
			chk("prbs10 errs", errs, 0);
			wr(8'h00, 32'h0000_0002, 2'h0);
			rd("builtin_pattern_test status", 8'h10, 32'h0000_000e, 2'h0);
			@(posedge clock);
			serial_loop_en <= 4'h0;
			wr(8'h04, 32'h0000_0002, 2'h0);
			rd("refused", 8'h18, 32'h4000_0000, 2'h0);
			rd("status", 8'h10, 32'h0000_0010, 2'h0);
			wr(8'h04, 32'h0000_0000, 2'h0);
		end
	endtask
	task t_rev;
		begin
			wr(8'h0c, 32'h0000_0035, 2'h0);
			wr(8'h04, 32'h0000_0003, 2'h0);
			repeat (2) @(negedge clock);
			chk("rser tx", line_tx_data[19:0], rec_q[19:0]);
			chk("rser rx", core_rx_data[19:0], rec_q[19:0]);
			wr(8'h00, 32'h0000_000a, 2'h0);
			errs = 0;
			repeat (8) @(negedge clock);
			chk("foreign errs", errs > 0, 1'h1);
			wr(8'h00, 32'h0000_0000, 2'h0);
			wr(8'h04, 32'h0000_0004, 2'h0);
			repeat (2) @(negedge clock);
			chk("pre tx", line_tx_data[19:0], pre_q[19:0]);
			chk("pre emph", line_tx_emph_on[1:0], 2'h2);
			chk("swing", line_tx_swing, 3'h5);
			chk("emph", line_tx_emph, 3'h3);
			chk("pre rx", core_rx_data[19:0], rec_q[19:0]);
			wr(8'h04, 32'h0000_0000, 2'h0);
		end
	endtask
	task t_freeze;
		reg [19:0] held;
		begin
			@(posedge clock);
			ce <= 1'h0;
			@(negedge clock);
			held = core_rx_data[19:0];
			repeat (3) @(negedge clock);
			chk("frozen rx", core_rx_data[19:0], held);
			chk("frozen ready", s_axi_arready, 1'h0);
			@(posedge clock);
			ce <= 1'h1;
		end
	endtask

	initial begin
		rst_b = 1'h0;
		ce = 1'h1;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h0000_0000;
		s_axi_wstrb = 4'hf;
		serial_loop_en = 4'h0;
		pipe_loop_req = 4'h0;
		core_tx_data = 80'h0;
		bad_count = 0;
		compares = 0;
		errs = 0;
		repeat (5) @(posedge clock);
		rst_b <= 1'h1;
		t_regs;
		t_serial;
		t_pipe;
		t_builtin_pattern_test;
		t_rev;
		t_freeze;
		test_done;
	end
endmodule
